// file: dv/sicr_host.sv
// apb host model that issues register transfers
`timescale 1ns/1ps
module sicr_host (
  input  wire logic                    i_clk, // clock
  input  wire sicr_pkg::sicr_apb_rsp_t i_rsp, // slave answer
  output sicr_pkg::sicr_apb_req_t      o_req, // request
  output logic                         o_tmo  // wait ran out
);
  initial
  begin
    o_req = '0;
    o_tmo = 1'b0;
  end
  // call right after a rising edge; holds the request until pready
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
    int n;
    o_req.psel    <= 1'b1;
    o_req.penable <= 1'b0;
    o_req.pwrite  <= w;
    o_req.paddr   <= a;
    o_req.pwdata  <= d;
    o_req.pstrb   <= s;
    @(posedge i_clk);
    o_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50)
      o_tmo <= 1'b1;
  endtask
  // released address and data lines show the inverse of their last value
  task automatic idle();
    o_req.psel    <= 1'b0;
    o_req.penable <= 1'b0;
    o_req.paddr   <= ~o_req.paddr;
    o_req.pwdata  <= ~o_req.pwdata;
    @(posedge i_clk);
  endtask
endmodule

// file: dv/sicr_regs_asserts.sv
// port-level assertions for the config bank
`timescale 1ns/1ps
`include "sicr_map.svh"
module sicr_regs_asserts #(
  parameter int N_IN = 24
) (
  input wire logic                        i_clk,          // clock
  input wire logic                        i_sys_rst,      // reset
  input wire sicr_pkg::sicr_apb_req_t     i_apb,          // apb request
  input wire sicr_pkg::sicr_apb_rsp_t     o_apb,          // apb response
  input wire logic                        i_pulse_active, // pulse phase
  input wire logic [3:0]                  i_cur_level,    // level bits
  input wire logic [23:0]                 o_pulse_sel,    // select reg
  input wire logic [11:0]                 o_thr_field,    // threshold reg
  input wire logic [N_IN-1:0]             o_pulse_on,     // enables
  input wire logic [N_IN-1:0][3:0]        o_pulse_ma,     // levels
  input wire logic [N_IN-1:0][1:0]        o_thr_code,     // codes
  input wire sicr_pkg::sicr_mv_t [N_IN-1:0] o_thr_mv      // millivolts
);
  // ****************************************************************
  // checks
  // ****************************************************************
  wire acc = i_apb.psel & i_apb.penable & o_apb.pready;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_pulse_gate: assert property (o_pulse_on == ($past(o_pulse_sel)
    & {N_IN{$past(i_pulse_active)}})) else $error("pulse enable wrong");
  a_pulse_off: assert property ((o_pulse_on & ~$past(o_pulse_sel)) == '0)
    else $error("pulse on without select");
  a_cur_level: assert property (o_pulse_ma[N_IN-1] == (o_pulse_on[N_IN-1]
    ? ($past(i_cur_level[3]) ? 4'hf : 4'ha) : 4'h0))
    else $error("current level wrong");
  a_grp_high: assert property (o_thr_code[22] == $past(o_thr_field[11:10]))
    else $error("upper group code wrong");
  a_grp_mid: assert property (o_thr_code[9] == $past(o_thr_field[5:4]))
    else $error("middle group code wrong");
  a_grp_low: assert property (o_thr_code[3] == $past(o_thr_field[1:0]))
    else $error("lowest group code wrong");
  a_thr_level: assert property (o_thr_mv[N_IN-1] ==
    (o_thr_code[N_IN-1] == 2'h3 ? 12'hfa0 : o_thr_code[N_IN-1] == 2'h2 ?
    12'hbb8 : o_thr_code[N_IN-1] == 2'h1 ? 12'ha8c : 12'h7d0))
    else $error("threshold level wrong");
  a_rsv_zero: assert property (acc && i_apb.paddr == 12'h084 |->
    o_apb.prdata[31:12] == '0) else $error("reserved bits not zero");
  a_sel_write: assert property (acc && i_apb.pwrite &&
    i_apb.paddr == 12'h080 && i_apb.pstrb == 4'hf |=>
    o_pulse_sel == $past(i_apb.pwdata[23:0])) else $error("select not written");
  a_sel_read: assert property (acc && !i_apb.pwrite &&
    i_apb.paddr == 12'h080 |-> o_apb.prdata == {8'h00, o_pulse_sel})
    else $error("select read wrong");
endmodule
bind sicr_regs sicr_regs_asserts #(.N_IN(N_IN)) u_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_apb(i_apb), .o_apb(o_apb),
  .i_pulse_active(i_pulse_active), .i_cur_level(i_cur_level),
  .o_pulse_sel(o_pulse_sel), .o_thr_field(o_thr_field),
  .o_pulse_on(o_pulse_on), .o_pulse_ma(o_pulse_ma),
  .o_thr_code(o_thr_code), .o_thr_mv(o_thr_mv));

// file: dv/sicr_regs_bench.sv
// self-checking bench for the config bank
`timescale 1ns/1ps
module sicr_regs_bench;
  logic                    clk, rst, act, tmo;
  logic [3:0]              lvl;
  sicr_pkg::sicr_apb_req_t req;
  sicr_pkg::sicr_apb_rsp_t rsp;
  logic [23:0]             sel, on;
  logic [11:0]             thr;
  logic [23:0][3:0]        ma;
  logic [23:0][1:0]        code;
  sicr_pkg::sicr_mv_t [23:0] mv;
  logic [33:0]             notes[$];
  logic [33:0]             n;
  logic [31:0]             r, q;
  logic [11:0]             lvmv[4] = '{12'd2000, 12'd2700, 12'd3000, 12'd4000};
  int                      err_total, cmp_count, seed, i, j;
  sicr_regs dut (.i_clk(clk), .i_sys_rst(rst), .i_apb(req), .o_apb(rsp),
    .i_pulse_active(act), .i_cur_level(lvl), .o_pulse_sel(sel),
    .o_thr_field(thr), .o_pulse_on(on), .o_pulse_ma(ma),
    .o_thr_code(code), .o_thr_mv(mv));
  sicr_host u_host (.i_clk(clk), .i_rsp(rsp), .o_req(req), .o_tmo(tmo));
  // ****************************************************************
  // checking and reporting
  // ****************************************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task op(input logic w, input logic [11:0] a, input logic [31:0] d,
          input logic [3:0] s, input logic e, input logic [31:0] x);
    notes.push_back({~w, e, x});
    u_host.xfer(a, w, d, s);
  endtask
  task end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
    if (req.psel && req.penable && rsp.pready === 1'b1)
    begin
      n = notes.pop_front();
      chk("pslverr", {31'h0, n[32]}, {31'h0, rsp.pslverr});
      if (n[33])
        chk("prdata", n[31:0], rsp.prdata);
    end
  always @(posedge tmo)
  begin
    err_total++;
    end_sim();
  end
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    seed = 32'h345c;
    rst = 1'b1;
    act = 1'b0;
    lvl = 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    op(1'b0, 12'h080, 32'h0, 4'h0, 1'b0, 32'h0);
    op(1'b0, 12'h084, 32'h0, 4'h0, 1'b0, 32'h0);
    u_host.idle();
    $display("test reset values done");
    for (i = 0; i < 6; i++)
    begin
      r = $random(seed);
      op(1'b1, 12'h080, r, 4'hf, 1'b0, 32'h0);
      op(1'b0, 12'h080, 32'h0, 4'h0, 1'b0, {8'h00, r[23:0]});
    end
    q = $random(seed);
    op(1'b1, 12'h080, q, 4'h2, 1'b0, 32'h0);
    op(1'b0, 12'h080, 0, 0, 0, {8'h0, r[23:16], q[15:8], r[7:0]});
    u_host.idle();
    $display("test select access done");
    for (i = 0; i < 4; i++)
    begin
      r = (i == 0) ? 32'hfffff4e4 : $random(seed);
      op(1'b1, 12'h084, r, 4'hf, 1'b0, 32'h0);
      op(1'b0, 12'h084, 32'h0, 4'h0, 1'b0, {20'h0, r[11:0]});
      u_host.idle();
      repeat (2) @(posedge clk);
      for (j = 0; j < 24; j++)
      begin
        chk("thr_code", {30'h0, r[2*(j/4)+:2]},
            {30'h0, code[j]});
        chk("thr_mv", {20'h0, lvmv[r[2*(j/4)+:2]]},
            {20'h0, mv[j]});
      end
    end
    $display("test thresholds done");
    for (i = 0; i < 4; i++)
    begin
      r = $random(seed);
      op(1'b1, 12'h080, r, 4'hf, 1'b0, 32'h0);
      u_host.idle();
      act <= i[0];
      lvl <= r[27:24];
      repeat (3) @(posedge clk);
      for (j = 0; j < 24; j++)
      begin
        chk("pulse_on", {31'h0, r[j] & act},
            {31'h0, on[j]});
        chk("pulse_ma", (r[j] & act) ? (lvl[j/6] ? 4'hf : 4'ha) : 4'h0,
            {28'h0, ma[j]});
      end
    end
    $display("test pulse current done");
    op(1'b1, 12'h088, 32'hffffffff, 4'hf, 1'b1, 32'h0);
    op(1'b0, 12'h088, 32'h0, 4'h0, 1'b1, 32'h0);
    op(1'b1, 12'h0c0, 32'hffffffff, 4'hf, 1'b1, 32'h0);
    op(1'b0, 12'h0c0, 32'h0, 4'h0, 1'b0,
       {8'h00, r[23:0] & {24{act}}});
    op(1'b0, 12'h080, 32'h0, 4'h0, 1'b0, {8'h00, r[23:0]});
    u_host.idle();
    repeat (2) @(posedge clk);
    $display("test refused access done");
    end_sim();
  end
endmodule

// file: hdl/sicr_map.svh
// register map, field layout, reset values and encodings of the config bank
//
// Function
// - 24-bit read/write pulse select at index 0x20, bit n is input n, resets 0
// - select bit 0 keeps cleaning-pulse current off that input
// - select bit 1 drives cleaning-pulse current while pulse operation runs
// - threshold register at index 0x21 resets 0; bits 31:12 read zero
// - threshold codes 0..3 select 2 V, 2.7 V, 3 V, 4 V
// - bits 11:10 inputs 20-23, 9:8 inputs 16-19, 7:6 inputs 12-15
// - bits 5:4 govern inputs 8-11, bits 3:2 govern inputs 4-7
// - bits 1:0 govern inputs 0-3 with the same encoding
// - pulse current per six-input group: bit 0 is 10 mA, bit 1 is 15 mA
`ifndef SICR_MAP_SVH
`define SICR_MAP_SVH

// ****************************************************************
// register indices; byte address is four times the index
// ****************************************************************
`define SICR_IDX_PULSE_SEL 8'h20
`define SICR_IDX_THRESHOLD 8'h21
`define SICR_IDX_STATUS    8'h30

// ****************************************************************
// widths and reset values
// ****************************************************************
`define SICR_NUM_INPUTS    24
`define SICR_SEL_W         24
`define SICR_THR_W         12
`define SICR_THR_GRP       4
`define SICR_CUR_GRP       6
`define SICR_CUR_GRPS      4
`define SICR_SEL_RST       24'h000000
`define SICR_THR_RST       12'h000

// ****************************************************************
// threshold levels in millivolts, current levels in milliamperes
// ****************************************************************
`define SICR_MV_CODE0      12'h7d0
`define SICR_MV_CODE1      12'ha8c
`define SICR_MV_CODE2      12'hbb8
`define SICR_MV_CODE3      12'hfa0
`define SICR_MA_LOW        4'ha
`define SICR_MA_HIGH       4'hf
`define SICR_MA_OFF        4'h0

`endif

// file: hdl/sicr_pkg.sv
// types and shared decoding for the switch input config bank
`include "sicr_map.svh"
package sicr_pkg;

  typedef logic [11:0] sicr_mv_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } sicr_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sicr_apb_rsp_t;

  // threshold code to level in millivolts
  function automatic sicr_mv_t code_to_mv(input logic [1:0] code);
    sicr_mv_t mv;
    mv = `SICR_MV_CODE0;
    unique case (code)
      2'h0: mv = `SICR_MV_CODE0;
      2'h1: mv = `SICR_MV_CODE1;
      2'h2: mv = `SICR_MV_CODE2;
      2'h3: mv = `SICR_MV_CODE3;
    endcase
    return mv;
  endfunction

endpackage

// file: hdl/sicr_regs.sv
// apb register bank steering cleaning-pulse current and thresholds
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "sicr_map.svh"
module sicr_regs #(
  parameter int N_IN   = `SICR_NUM_INPUTS,
  parameter int ADDR_W = 12
) (
  input  wire logic                   i_clk,          // system clock
  input  wire logic                   i_sys_rst,      // async reset, high
  input  wire sicr_pkg::sicr_apb_req_t i_apb,         // apb request
  output sicr_pkg::sicr_apb_rsp_t     o_apb,          // apb response
  input  wire logic                   i_pulse_active, // pulse phase running
  input  wire logic [`SICR_CUR_GRPS-1:0] i_cur_level, // group level bits
  output logic [`SICR_SEL_W-1:0]      o_pulse_sel,    // select register
  output logic [`SICR_THR_W-1:0]      o_thr_field,    // threshold register
  output logic [N_IN-1:0]             o_pulse_on,     // current enable
  output logic [N_IN-1:0][3:0]        o_pulse_ma,     // current level, mA
  output logic [N_IN-1:0][1:0]        o_thr_code,     // threshold code
  output sicr_pkg::sicr_mv_t [N_IN-1:0] o_thr_mv      // threshold, mV
);

  // ****************************************************************
  // local types and helpers
  // ****************************************************************
  typedef enum {
    SICR_SEL_NONE,
    SICR_SEL_PULSE,
    SICR_SEL_THR,
    SICR_SEL_STAT
  } sicr_reg_sel_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] idx_addr(input logic [7:0] idx);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[9:2] = idx;
    return a;
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // decode an address to a register
  function automatic sicr_reg_sel_t decode(input logic [ADDR_W-1:0] a);
    sicr_reg_sel_t s;
    s = SICR_SEL_NONE;
    if (a == idx_addr(`SICR_IDX_PULSE_SEL))
    begin
      s = SICR_SEL_PULSE;
    end
    else if (a == idx_addr(`SICR_IDX_THRESHOLD))
    begin
      s = SICR_SEL_THR;
    end
    else if (a == idx_addr(`SICR_IDX_STATUS))
    begin
      s = SICR_SEL_STAT;
    end
    return s;
  endfunction

  // ****************************************************************
  // bus phase tracking
  // ****************************************************************
  sicr_reg_sel_t            req_sel;
  logic                     setup_phase;
  logic                     wr_commit;
  logic [31:0]              next_pulse_word;
  logic [31:0]              next_thr_word;
  logic [31:0]              read_word;
  logic [ADDR_W-1:0]        req_addr;

  assign req_addr    = i_apb.paddr[ADDR_W-1:0];
  assign req_sel     = decode(req_addr);
  assign setup_phase = i_apb.psel & ~i_apb.penable;

  // the write lands only at the edge that sees pready high
  assign wr_commit = i_apb.psel & i_apb.penable & o_apb.pready
                     & i_apb.pwrite;

  // ****************************************************************
  // write data shaping
  // ****************************************************************
  always_comb
  begin
    next_pulse_word = merge_lanes({8'h00, o_pulse_sel},
                                  i_apb.pwdata, i_apb.pstrb);
    next_thr_word   = merge_lanes({20'h00000, o_thr_field},
                                  i_apb.pwdata, i_apb.pstrb);
  end

  // ****************************************************************
  // pulse select register
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pulse_sel <= `SICR_SEL_RST;
    end
    else if (wr_commit && req_sel == SICR_SEL_PULSE)
    begin
      // bits above 23 have no storage
      o_pulse_sel <= next_pulse_word[`SICR_SEL_W-1:0];
    end
  end

  // ****************************************************************
  // threshold register
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_thr_field <= `SICR_THR_RST;
    end
    else if (wr_commit && req_sel == SICR_SEL_THR)
    begin
      // reserved bits 31:12 are dropped here
      o_thr_field <= next_thr_word[`SICR_THR_W-1:0];
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb
  begin
    read_word = 32'h00000000;
    unique case (req_sel)
      SICR_SEL_PULSE:
      begin
        read_word = {8'h00, o_pulse_sel};
      end
      SICR_SEL_THR:
      begin
        read_word = {20'h00000, o_thr_field};
      end
      SICR_SEL_STAT:
      begin
        read_word = {8'h00, o_pulse_on};
      end
      SICR_SEL_NONE:
      begin
        read_word = 32'h00000000;
      end
    endcase
  end

  // ****************************************************************
  // apb response: one wait-free access phase
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_apb.pready <= 1'b0;
    end
    else
    begin
      // ready rises in the access cycle, falls after completion
      o_apb.pready <= setup_phase;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_apb.pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      // unmapped address, or a write to the read-only status word
      o_apb.pslverr <= (req_sel == SICR_SEL_NONE)
                       | (i_apb.pwrite & (req_sel == SICR_SEL_STAT));
    end
    else
    begin
      o_apb.pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_apb.prdata <= 32'h00000000;
    end
    else if (setup_phase && !i_apb.pwrite)
    begin
      o_apb.prdata <= read_word;
    end
    else
    begin
      o_apb.prdata <= 32'h00000000;
    end
  end

  // ****************************************************************
  // cleaning-pulse current per input
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pulse_on <= '0;
    end
    else
    begin
      // off when deselected, on only while pulses run
      o_pulse_on <= o_pulse_sel & {N_IN{i_pulse_active}};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pulse_ma <= '0;
    end
    else
    begin
      for (int i = 0; i < N_IN; i++)
      begin
        if (!(o_pulse_sel[i] && i_pulse_active))
        begin
          o_pulse_ma[i] <= `SICR_MA_OFF;
        end
        else if (i_cur_level[i/`SICR_CUR_GRP])
        begin
          o_pulse_ma[i] <= `SICR_MA_HIGH;
        end
        else
        begin
          o_pulse_ma[i] <= `SICR_MA_LOW;
        end
      end
    end
  end

  // ****************************************************************
  // threshold expansion
  // ****************************************************************
  sicr_thr_decode #(
    .N_IN        (N_IN)
  ) u_thr_decode (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_thr_field (o_thr_field),
    .o_thr_code  (o_thr_code),
    .o_thr_mv    (o_thr_mv)
  );

endmodule

// file: hdl/sicr_thr_decode.sv
// expands the threshold register into per-input codes and levels
`timescale 1ns/1ps
`include "sicr_map.svh"
module sicr_thr_decode #(
  parameter int N_IN = `SICR_NUM_INPUTS
) (
  input  wire logic                   i_clk,       // system clock
  input  wire logic                   i_sys_rst,   // async reset, high
  input  wire logic [`SICR_THR_W-1:0] i_thr_field, // threshold register
  output logic [N_IN-1:0][1:0]        o_thr_code,  // code per input
  output sicr_pkg::sicr_mv_t [N_IN-1:0] o_thr_mv   // level per input
);

  // ****************************************************************
  // per-input decode, each group of four shares one field
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_thr_code <= '0;
      o_thr_mv   <= {N_IN{`SICR_MV_CODE0}};
    end
    else
    begin
      for (int i = 0; i < N_IN; i++)
      begin
        // field index is input / 4
        o_thr_code[i] <= i_thr_field[2*(i/`SICR_THR_GRP) +: 2];
        o_thr_mv[i]   <= sicr_pkg::code_to_mv(
                           i_thr_field[2*(i/`SICR_THR_GRP) +: 2]);
      end
    end
  end

endmodule
